// >>> design/lrso_link_if.sv
// radio packet link between the remote sender and the switch receiver
`timescale 1ns/1ps
interface lrso_link_if;
    logic        pkt_valid;      // one payload byte this cycle
    logic [7:0]  pkt_data;       // payload byte, first byte is the state byte
    logic        pkt_last;       // marks the final byte of a packet
    logic [31:0] pkt_hdr_serial; // sender serial number from the packet header

    modport sender   (output pkt_valid, output pkt_data, output pkt_last, output pkt_hdr_serial);
    modport receiver (input pkt_valid, input pkt_data, input pkt_last, input pkt_hdr_serial);
endinterface : lrso_link_if

// >>> design/lrso_pkg.sv
// shared constants for the switch-logic receiver and its remote sender
package lrso_pkg;
    // clock and times
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned HOLD_LONG_MS  = 500;
    localparam int unsigned HOLD_SHORT_MS = 20;
    localparam int unsigned TX_GAP_MS     = 15;
    localparam int unsigned HOLD_LONG_CYC  = HOLD_LONG_MS * CYC_PER_MS;
    localparam int unsigned HOLD_SHORT_CYC = HOLD_SHORT_MS * CYC_PER_MS;
    localparam int unsigned TX_GAP_CYC     = TX_GAP_MS * CYC_PER_MS;
    localparam int unsigned CNT_W          = 24;
    typedef logic [CNT_W-1:0] lrso_cnt_t;

    // payload layout
    localparam int unsigned OUT_LSB    = 4;
    localparam int unsigned OUT_MSB    = 6;
    localparam int unsigned BEACON_BIT = 0;
    localparam logic [2:0]  LEN_SHORT  = 3'h1;
    localparam logic [2:0]  LEN_LONG   = 3'h5;
    localparam logic [7:0]  BEACON_MASK = 8'h11;

    // learned serial table
    localparam int unsigned SERIAL_DEPTH = 8;
    localparam int unsigned SERIAL_AW    = 3;

    // sender register map (byte offsets) and fields
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_SERIAL = 8'h04;
    localparam logic [7:0] REG_CMD    = 8'h08;
    localparam logic [7:0] REG_TARGET = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_BEACON = 8'h14;
    localparam int unsigned CTRL_EN_BIT   = 3;
    localparam int unsigned CMD_ADDR_BIT  = 8;
    localparam logic [3:0]  CTRL_RST      = 4'h0;
    localparam logic [31:0] SERIAL_RST    = 32'h0000_0000;

    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_GAP} lrso_tx_e;
endpackage : lrso_pkg

// >>> design/lrso_receiver.sv
// switch-logic receiver: decodes packets into three held switch outputs
// Function
// - Receiver only listens, never transmits
// - Accepted packet sets three outputs from state
// - Strap1 low: hold 500ms without new data
// - Strap1 high: hold only 20ms
// - Straps 101: filtered, long hold
// - Straps 110: unfiltered, short hold, pin unused
// - Straps 111: filtered, short hold
// - Learn pin: pulse enters learning, drives status
// - Sender quiet while all inputs low
// - Sender repeats state every 15ms
// - Sender payload: state byte plus serial
// - State bits 6..4 carry inputs 3..1
// - Beacon sets bits 0 and 4
// - Filtered end drops unlearned header serials
// - Command packets decoded like transmitter packets
// - Command sender idles 15ms after packet
// - Single zero byte clears outputs at once
// - Unfiltered receiver accepts every packet
// - Filtered receiver needs learned header serial
// - Filtered five-byte form must carry own serial
// - Learning stores header serial only
// - Straps 100: unfiltered, long hold
`timescale 1ns/1ps
module lrso_receiver
    import lrso_pkg::*;
#(
    parameter int unsigned HOLD_LONG  = lrso_pkg::HOLD_LONG_CYC,
    parameter int unsigned HOLD_SHORT = lrso_pkg::HOLD_SHORT_CYC,
    parameter logic [31:0] OWN_SERIAL = 32'h5A5A_0001  // arbitrary unit serial number
) (
    // clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // radio side, receive only
    lrso_link_if.receiver        link,
    // mode straps
    input  wire logic [2:0]      mode_strap,
    // learn / status pin
    input  wire logic            learn_in,
    output logic                 learn_out,
    output logic                 learn_oe_n,
    // switch outputs
    output logic                 switch_out_a,
    output logic                 switch_out_b,
    output logic                 switch_out_c
);
    import lrso_pkg::*;

    logic [2:0]       strap_s1;
    logic [2:0]       strap_s2;
    logic             learn_s1;
    logic             learn_s2;
    logic             learn_s3;
    logic             rx_on;
    logic             net_mode;
    logic             hold_long;
    logic             learning;
    logic [31:0]      serial_tbl [SERIAL_DEPTH];
    logic [SERIAL_DEPTH-1:0] serial_vld;
    logic [SERIAL_AW-1:0]    serial_wp;
    logic             hdr_known;
    logic [2:0]       byte_cnt;
    logic [7:0]       state_byte;
    logic [31:0]      pay_serial;
    logic [2:0]       cur_len;
    logic [7:0]       cur_state;
    logic [31:0]      cur_pay;
    logic             pkt_end;
    logic             accept;
    logic [2:0]       next_outs;
    lrso_cnt_t        hold_cnt;
    logic             hold_act;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
            learn_s1 <= 1'b0;
            learn_s2 <= 1'b0;
            learn_s3 <= 1'b0;
        end else begin
            strap_s1 <= mode_strap;
            strap_s2 <= strap_s1;
            learn_s1 <= learn_in;
            learn_s2 <= learn_s1;
            learn_s3 <= learn_s2;
        end
    end

    // mode decode: strap2 enables the receiver, strap0 filters, strap1 picks hold
    assign rx_on     = strap_s2[2];
    assign net_mode  = strap_s2[2] & strap_s2[0];
    assign hold_long = ~strap_s2[1];

    ////////////////////////////////////////////////////////////////////////
    // learn state: pulse enters, one stored serial leaves
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            learning <= 1'b0;
        end else if (!net_mode) begin
            learning <= 1'b0;
        end else if (learning && pkt_end) begin
            learning <= 1'b0;
        end else if (learn_s2 && !learn_s3) begin
            learning <= 1'b1;
        end
    end

    // status pin is driven high only while learning, released otherwise
    assign learn_out  = 1'b1;
    assign learn_oe_n = ~learning;

    // learned serial table, written round robin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_vld <= '0;
            serial_wp  <= '0;
        end else if (learning && pkt_end) begin
            serial_vld[serial_wp] <= 1'b1;
            serial_wp             <= serial_wp + 1'b1;
        end
    end

    always_ff @(posedge hclk) begin
        if (learning && pkt_end) begin
            serial_tbl[serial_wp] <= link.pkt_hdr_serial;
        end
    end

    // header serial lookup
    always_comb begin
        hdr_known = 1'b0;
        for (int i = 0; i < SERIAL_DEPTH; i++) begin
            if (serial_vld[i] && serial_tbl[i] == link.pkt_hdr_serial) begin
                hdr_known = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte collection: state byte then up to four serial bytes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            byte_cnt   <= 3'h0;
            state_byte <= 8'h00;
            pay_serial <= 32'h0000_0000;
        end else if (link.pkt_valid) begin
            byte_cnt   <= link.pkt_last ? 3'h0 : cur_len;
            state_byte <= cur_state;
            pay_serial <= cur_pay;
        end
    end

    // view of the packet including the byte on the link now
    always_comb begin
        cur_len   = (byte_cnt == LEN_LONG) ? LEN_LONG : byte_cnt + 3'h1;
        cur_state = (byte_cnt == 3'h0) ? link.pkt_data : state_byte;
        cur_pay   = pay_serial;
        if (byte_cnt != 3'h0 && byte_cnt != LEN_LONG) begin
            cur_pay = {pay_serial[23:0], link.pkt_data};
        end
    end

    assign pkt_end = link.pkt_valid & link.pkt_last;

    // acceptance: any packet when unfiltered, learned header and, for the five-byte form, own address when filtered
    always_comb begin
        accept = 1'b0;
        if (pkt_end && rx_on && !learning) begin
            if (!net_mode) begin
                accept = 1'b1;
            end else if (hdr_known) begin
                accept = (cur_len != LEN_LONG) || (cur_pay == OWN_SERIAL);
            end
        end
    end

    assign next_outs = cur_state[OUT_MSB:OUT_LSB];

    ////////////////////////////////////////////////////////////////////////
    // outputs and hold timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            switch_out_a <= 1'b0;
            switch_out_b <= 1'b0;
            switch_out_c <= 1'b0;
            hold_cnt     <= '0;
            hold_act     <= 1'b0;
        end else if (accept) begin
            switch_out_a <= next_outs[0];
            switch_out_b <= next_outs[1];
            switch_out_c <= next_outs[2];
            hold_cnt     <= hold_long ? lrso_cnt_t'(HOLD_LONG) : lrso_cnt_t'(HOLD_SHORT);
            hold_act     <= |next_outs;
        end else if (hold_act) begin
            if (hold_cnt <= lrso_cnt_t'(1)) begin
                switch_out_a <= 1'b0;
                switch_out_b <= 1'b0;
                switch_out_c <= 1'b0;
                hold_act     <= 1'b0;
                hold_cnt     <= '0;
            end else begin
                hold_cnt <= hold_cnt - lrso_cnt_t'(1);
            end
        end
    end
endmodule : lrso_receiver

// >>> design/lrso_sender.sv
// remote sender: logic transmitter and command sender behind an AHB-Lite slave
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
module lrso_sender
    import lrso_pkg::*;
#(
    parameter int unsigned GAP_CYC = lrso_pkg::TX_GAP_CYC
) (
    // clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic [31:0]          hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    // radio side
    lrso_link_if.sender          link
);
    import lrso_pkg::*;

    logic [3:0]   ctrl;
    logic [31:0]  own_serial;
    logic [31:0]  target;
    logic [8:0]   cmd;
    logic         cmd_pend;
    logic         beacon_pend;
    logic         wr_pend;
    logic [7:0]   wr_addr;
    logic         addr_ok;
    logic         cmd_take;
    logic         bcn_take;
    logic         logic_take;
    lrso_tx_e     tx_state;
    logic [39:0]  tx_buf;
    logic [2:0]   tx_len;
    logic [2:0]   tx_idx;
    logic         tx_periodic;
    lrso_cnt_t    gap_cnt;
    logic [31:0]  rd_val;
    logic         busy;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel & htrans[1] & hready;
    assign busy      = (tx_state != TX_IDLE) | cmd_pend | beacon_pend;

    ////////////////////////////////////////////////////////////////////////
    // bus address phase capture and read data
    always_comb begin
        case (haddr[7:0])
            REG_CTRL:   rd_val = {28'h0000000, ctrl};
            REG_SERIAL: rd_val = own_serial;
            REG_CMD:    rd_val = {23'h000000, cmd};
            REG_TARGET: rd_val = target;
            REG_STATUS: rd_val = {30'h00000000, tx_state != TX_IDLE, busy};
            default:    rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata  <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr <= haddr[7:0];
                hrdata  <= hwrite ? 32'h0000_0000 : rd_val;
            end
        end
    end

    // register writes in the data phase; a command or beacon already pending is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl        <= CTRL_RST;
            own_serial  <= SERIAL_RST;
            target      <= SERIAL_RST;
            cmd         <= 9'h000;
            cmd_pend    <= 1'b0;
            beacon_pend <= 1'b0;
        end else begin
            if (cmd_take) begin
                cmd_pend <= 1'b0;
            end
            if (bcn_take) begin
                beacon_pend <= 1'b0;
            end
            if (wr_pend) begin
                case (wr_addr)
                    REG_CTRL:   ctrl       <= hwdata[3:0];
                    REG_SERIAL: own_serial <= hwdata;
                    REG_TARGET: target     <= hwdata;
                    REG_CMD: begin
                        if (!cmd_pend) begin
                            cmd      <= hwdata[8:0];
                            cmd_pend <= 1'b1;
                        end
                    end
                    REG_BEACON: beacon_pend <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // packet source choice: command, then beacon, then input state
    assign cmd_take   = (tx_state == TX_IDLE) & cmd_pend;
    assign bcn_take   = (tx_state == TX_IDLE) & ~cmd_pend & beacon_pend;
    assign logic_take = (tx_state == TX_IDLE) & ~cmd_pend & ~beacon_pend
                        & ctrl[CTRL_EN_BIT] & (|ctrl[2:0]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state    <= TX_IDLE;
            tx_buf      <= 40'h00_0000_0000;
            tx_len      <= 3'h0;
            tx_idx      <= 3'h0;
            tx_periodic <= 1'b0;
            gap_cnt     <= '0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_idx <= 3'h0;
                    if (cmd_take) begin
                        tx_buf      <= {cmd[7:0], target};
                        tx_len      <= cmd[CMD_ADDR_BIT] ? LEN_LONG : LEN_SHORT;
                        tx_periodic <= 1'b0;
                        tx_state    <= TX_SEND;
                    end else if (bcn_take) begin
                        tx_buf      <= {{1'b0, ctrl[2:0], 4'h0} | BEACON_MASK, own_serial};
                        tx_len      <= LEN_LONG;
                        tx_periodic <= 1'b0;
                        tx_state    <= TX_SEND;
                    end else if (logic_take) begin
                        tx_buf      <= {1'b0, ctrl[2:0], 4'h0, own_serial};
                        tx_len      <= LEN_LONG;
                        tx_periodic <= 1'b1;
                        tx_state    <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    tx_buf <= {tx_buf[31:0], 8'h00};
                    tx_idx <= tx_idx + 3'h1;
                    if (tx_idx == tx_len - 3'h1) begin
                        // periodic packets repeat start to start, commands idle after last byte
                        gap_cnt  <= tx_periodic ? lrso_cnt_t'(GAP_CYC - 32'(LEN_LONG) - 32'd1)
                                                : lrso_cnt_t'(GAP_CYC);
                        tx_state <= TX_GAP;
                    end
                end
                TX_GAP: begin
                    if (gap_cnt <= lrso_cnt_t'(1)) begin
                        tx_state <= TX_IDLE;
                    end else begin
                        gap_cnt <= gap_cnt - lrso_cnt_t'(1);
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // link drive
    assign link.pkt_valid      = (tx_state == TX_SEND);
    assign link.pkt_last       = (tx_state == TX_SEND) & (tx_idx == tx_len - 3'h1);
    assign link.pkt_data       = tx_buf[39:32];
    assign link.pkt_hdr_serial = own_serial;
endmodule : lrso_sender

// >>> verification/lrso_link_checker.sv
// concurrent checks on the packet link and the receiver pins
`timescale 1ns/1ps
module lrso_link_checker #(
    parameter int unsigned HOLD_LONG  = 200,
    parameter int unsigned HOLD_SHORT = 40,
    parameter int unsigned GAP_CYC    = 30
) (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // packet link
    input wire logic       pkt_valid,
    input wire logic [7:0] pkt_data,
    input wire logic       pkt_last,
    // receiver pins
    input wire logic [2:0] mode_strap,
    input wire logic       learn_in,
    input wire logic       learn_oe_n,
    input wire logic       switch_out_a,
    input wire logic       switch_out_b,
    input wire logic       switch_out_c
);
    logic [2:0]  byte_cnt;
    logic [7:0]  first_q;
    logic [2:0]  last_state;
    logic [31:0] quiet_cnt;
    logic [31:0] idle_cnt;
    wire  [2:0]  outs = {switch_out_c, switch_out_b, switch_out_a};
    wire  [7:0]  head = (byte_cnt == 3'h0) ? pkt_data : first_q;
    wire  [31:0] hold = mode_strap[1] ? HOLD_SHORT : HOLD_LONG;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////////
    // byte position and state byte of the packet in flight
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            byte_cnt <= 3'h0;
            first_q  <= 8'h00;
        end else if (pkt_valid) begin
            byte_cnt <= pkt_last ? 3'h0 : byte_cnt + 3'h1;
            first_q  <= head;
        end
    end

    // cycles since the last packet ended, and idle cycles on the link
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_state <= 3'h0;
            quiet_cnt  <= 32'h0;
            idle_cnt   <= 32'hFFFF;
        end else begin
            if (pkt_valid && pkt_last) begin
                last_state <= head[6:4];
                quiet_cnt  <= 32'h0;
            end else if (quiet_cnt != 32'hFFFF) begin
                quiet_cnt <= quiet_cnt + 32'h1;
            end
            if (pkt_valid) begin
                idle_cnt <= 32'h0;
            end else if (idle_cnt != 32'hFFFF) begin
                idle_cnt <= idle_cnt + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    last_valid_a: assert property (pkt_last |-> pkt_valid)
        else $error("packet end marker without a byte");
    pkt_len_a: assert property (pkt_valid && pkt_last |-> (byte_cnt == 3'h0 || byte_cnt == 3'h4))
        else $error("packet is neither one nor five bytes");
    beacon_bits_a: assert property (pkt_valid && byte_cnt == 3'h0 && pkt_data[0] |-> pkt_data[4])
        else $error("beacon flag set without bit four");
    send_gap_a: assert property ($rose(pkt_valid) |-> idle_cnt + 5 >= GAP_CYC)
        else $error("packet started too soon after the previous one");
    apply_state_a: assert property (pkt_valid && pkt_last && mode_strap[2] && !mode_strap[0] && learn_oe_n
        |-> ##2 (outs == last_state))
        else $error("outputs do not follow the packet state");
    hold_max_a: assert property ((|outs) |-> quiet_cnt <= hold + 2)
        else $error("outputs held past the hang time");
    hold_min_a: assert property ($fell(|outs) && last_state != 3'h0 && mode_strap[2] && !mode_strap[0]
        |-> quiet_cnt + 2 >= hold)
        else $error("outputs released before the hang time");
    learn_enter_a: assert property ($rose(learn_in) && learn_oe_n && mode_strap[0] && mode_strap[2]
        |-> ##[1:6] !learn_oe_n)
        else $error("learn pulse did not start learning");
    learn_hold_a: assert property (!learn_oe_n && pkt_valid && pkt_last |=> ($stable(outs)) [*3])
        else $error("packet applied while learning");
    learn_done_a: assert property (!learn_oe_n && pkt_valid && pkt_last |-> ##[1:3] learn_oe_n)
        else $error("learning did not end after a packet");
    pin_unused_a: assert property ((!mode_strap[0]) [*4] |-> learn_oe_n)
        else $error("status pin driven in an unfiltered mode");
endmodule : lrso_link_checker

// >>> verification/tb_top.sv
// testbench: sender and receiver joined by the link, driven over AHB-Lite
`timescale 1ns/1ps
module tb_top;
    import lrso_pkg::*;
    localparam int unsigned HL = 200, HS = 40, GAP = 30;
    localparam logic [31:0] RX_SN = 32'h1357_9BDF; // arbitrary value
    localparam logic [31:0] TX_SN = 32'h2468_ACE0; // arbitrary value
    localparam logic [31:0] XT_SN = 32'h7700_1122; // arbitrary value
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, learn_drv, learn_out, learn_oe_n;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, mode_strap;
    logic        switch_out_a, switch_out_b, switch_out_c;
    wire         learn_pin;
    int          fail_count, checks_done, pkt_count, plen, nb;
    logic [7:0]  pk [0:7];
    lrso_link_if link ();

    // pin level: receiver drives high, else the pull-down held by learn_drv
    assign learn_pin = !learn_oe_n ? learn_out : learn_drv;

    lrso_sender #(.GAP_CYC(GAP)) i_lrso_sender (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link));
    lrso_receiver #(.HOLD_LONG(HL), .HOLD_SHORT(HS), .OWN_SERIAL(RX_SN)) i_lrso_receiver (.hclk(hclk),
        .hresetn(hresetn), .link(link), .mode_strap(mode_strap), .learn_in(learn_pin), .learn_out(learn_out),
        .learn_oe_n(learn_oe_n), .switch_out_a(switch_out_a), .switch_out_b(switch_out_b),
        .switch_out_c(switch_out_c));
    lrso_link_checker #(.HOLD_LONG(HL), .HOLD_SHORT(HS), .GAP_CYC(GAP)) i_lrso_link_checker (.hclk(hclk),
        .hresetn(hresetn), .pkt_valid(link.pkt_valid), .pkt_data(link.pkt_data), .pkt_last(link.pkt_last),
        .mode_strap(mode_strap), .learn_in(learn_pin), .learn_oe_n(learn_oe_n),
        .switch_out_a(switch_out_a), .switch_out_b(switch_out_b), .switch_out_c(switch_out_c));

    ////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // record the bytes of each packet on the link
    always @(posedge hclk) begin
        if (link.pkt_valid === 1'b1) begin
            if (nb < 8) pk[nb] = link.pkt_data;
            nb = nb + 1;
            if (link.pkt_last === 1'b1) begin
                plen = nb;
                nb = 0;
                pkt_count = pkt_count + 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one single AHB-Lite transfer, address phase then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(what, {8'h00, exp}, {7'h00, hresp, r});
    endtask : rd_chk

    task automatic outs(input logic [2:0] e);
        chk("switch outputs", {29'h0, e}, {29'h0, switch_out_c, switch_out_b, switch_out_a});
    endtask : outs

    // wait until the sender is idle, issue one command, wait for its packet
    task automatic send(input logic [31:0] cmd);
        logic [31:0] s;
        int n;
        n = 0;
        do begin ahb(1'b0, REG_STATUS, 32'h0, s); n++; end while (s[1:0] !== 2'b00 && n < 100);
        n = pkt_count;
        wr(REG_CMD, cmd);
        for (int i = 0; i < 100 && pkt_count == n; i++) @(posedge hclk);
        repeat (3) @(posedge hclk);
    endtask : send

    task automatic hold_chk(input logic [2:0] e, input int unsigned hold);
        outs(e);
        repeat (hold - 10) @(posedge hclk);
        outs(e);
        repeat (14) @(posedge hclk);
        outs(3'h0);
    endtask : hold_chk

    task automatic set_mode(input logic [2:0] m);
        @(posedge hclk);
        mode_strap <= m;
        repeat (4) @(posedge hclk);
    endtask : set_mode

    ////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (30000) @(posedge hclk);
        fail_count++;
        $display("mismatch watchdog expected end seen timeout");
        test_done();
    end

    // main sequence
    initial begin
        {hsel, hwrite, haddr, htrans, hwdata, learn_drv, hresetn} = '0;
        hsize = 3'h2;
        mode_strap = 3'b100;
        {fail_count, checks_done, pkt_count, plen, nb} = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(REG_CTRL, {28'h0, CTRL_RST}, "ctrl reset");
        rd_chk(REG_SERIAL, SERIAL_RST, "serial reset");
        wr(8'h40, 32'hFFFF_FFFF);
        rd_chk(8'h40, 32'h0, "unmapped read");
        wr(REG_SERIAL, TX_SN);
        rd_chk(REG_SERIAL, TX_SN, "serial readback");
        for (int s = 1; s < 8; s++) begin
            send(s << 4);
            outs(s[2:0]);
        end
        send(32'h0);
        outs(3'h0);
        chk("one byte form length", 32'h1, plen);
        send(32'h50);
        hold_chk(3'b101, HL);
        wr(REG_TARGET, XT_SN);
        send(32'h130);
        outs(3'b011);
        chk("addressed bytes", XT_SN, {pk[1], pk[2], pk[3], pk[4]});
        send(32'h0);
        set_mode(3'b110);
        send(32'h60);
        hold_chk(3'b110, HS);
        learn_drv <= 1'b1;
        repeat (4) @(posedge hclk);
        learn_drv <= 1'b0;
        repeat (4) @(posedge hclk);
        chk("status pin released", 32'h1, {31'h0, learn_oe_n});
        wr(REG_CTRL, 32'h0000_000D);
        repeat (6 * GAP) @(posedge hclk);
        outs(3'b101);
        chk("periodic bytes", {8'h50, TX_SN}, {pk[0], pk[1], pk[2], pk[3], pk[4]});
        wr(REG_CTRL, 32'h0);
        send(32'h0);
        plen = pkt_count;
        repeat (HS + 10) @(posedge hclk);
        chk("quiet sender", plen, pkt_count);
        outs(3'h0);
        set_mode(3'b101);
        send(32'h30);
        outs(3'h0);
        learn_drv <= 1'b1;
        repeat (4) @(posedge hclk);
        learn_drv <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("learning pin", 32'h2, {30'h0, learn_pin, learn_oe_n});
        send(32'h170);
        outs(3'h0);
        chk("learning ended", 32'h1, {31'h0, learn_oe_n});
        wr(REG_SERIAL, XT_SN);
        send(32'h10);
        outs(3'h0);
        wr(REG_SERIAL, TX_SN);
        send(32'h20);
        outs(3'b010);
        send(32'h170);
        outs(3'b010);
        wr(REG_TARGET, RX_SN);
        send(32'h160);
        outs(3'b110);
        send(32'h0);
        set_mode(3'b111);
        send(32'h40);
        hold_chk(3'b100, HS);
        set_mode(3'b000);
        plen = pkt_count;
        wr(REG_BEACON, 32'h1);
        for (int i = 0; i < 100 && pkt_count == plen; i++) @(posedge hclk);
        chk("beacon bytes", {8'h11, TX_SN}, {pk[0], pk[1], pk[2], pk[3], pk[4]});
        chk("header serial", TX_SN, link.pkt_hdr_serial);
        repeat (3) @(posedge hclk);
        outs(3'h0);
        test_done();
    end
endmodule : tb_top
